// ---- bench/swd_dap_access_properties.sv ----
`timescale 1ns/1ns
module swd_dap_access_properties (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports.
  input wire logic link_clk_i,
  input wire logic link_data_i,
  input wire logic link_data_o,
  input wire logic link_data_oe_o,
  input wire logic [31:0] mem_read_data_i,
  input wire swd_pkg::mem_write_type mem_write_o,
  input wire logic [31:0] control_status_o,
  input wire logic abort_pulse_o,
  input wire logic line_synced_o
);
  import swd_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [8:0] oe_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || !link_data_oe_o) oe_cnt <= 9'h000;
    else oe_cnt <= oe_cnt + 9'h001;
  end
  // The target drives three link bits for an ack alone, thirty-six for an ack with read data.
  chk_drive_span: assert property ($fell(link_data_oe_o) |-> oe_cnt inside {[22:26], [285:291]})
    else $error("target drive span wrong");
  chk_synced_holds: assert property (line_synced_o |=> line_synced_o)
    else $error("line sync lost");
  chk_quiet_unsynced: assert property (!line_synced_o |-> !link_data_oe_o)
    else $error("target drove before line reset");
  chk_write_one_pulse: assert property (mem_write_o.valid |=> !mem_write_o.valid)
    else $error("data window write pulse too long");
  chk_abort_one_pulse: assert property (abort_pulse_o |=> !abort_pulse_o)
    else $error("abort pulse too long");
  chk_port_exclusive: assert property (!(abort_pulse_o && mem_write_o.valid))
    else $error("both ports written at once");
  chk_write_idle_line: assert property ((mem_write_o.valid || abort_pulse_o) |->
    line_synced_o && !link_data_oe_o)
    else $error("write effect while target drives");
  chk_status_on_write: assert property ($changed(control_status_o) |-> line_synced_o && !link_data_oe_o)
    else $error("status changed outside a write");
endmodule : swd_dap_access_properties

// ---- bench/swd_host_model.sv ----
`timescale 1ns/1ns
module swd_host_model (
  // Link pins.
  output logic link_clk_o,
  output logic data_o,
  output logic oe_o,
  input wire logic line_i,
  // Target reset and supply.
  output logic external_reset_pin_n_o,
  output logic supply_on_o
);
  import swd_pkg::*;
  initial begin
    link_clk_o = 1'b0;
    data_o = 1'b0;
    oe_o = 1'b1;
    external_reset_pin_n_o = 1'b1;
    supply_on_o = 1'b1;
  end
  // Data changes with the falling edge and is sampled late in the high phase.
  task automatic bitx(input logic d, input logic drv, output logic s);
    oe_o = drv;
    data_o = d;
    #80 link_clk_o = 1'b1;
    #70 s = line_i;
    #10 link_clk_o = 1'b0;
  endtask : bitx
  task automatic line_reset(input int n);
    logic s;
    repeat (n) bitx(1'b1, 1'b1, s);
    repeat (2) bitx(1'b0, 1'b1, s);
  endtask : line_reset
  // The reset pin is active low; the pulse and the settling time after it each last one link bit.
  task automatic pulse_target_reset();
    external_reset_pin_n_o = 1'b0;
    #160 external_reset_pin_n_o = 1'b1;
    #160;
  endtask : pulse_target_reset
  task automatic set_supply(input logic on);
    supply_on_o = on;
    #160;
  endtask : set_supply
  task automatic xfer(input logic ap, input logic rnw, input logic [1:0] a, input logic [31:0] wd,
                      input logic [1:0] bad, output logic [31:0] rd, output logic [2:0] ack);
    logic [7:0] h;
    logic s;
    logic p;
    rd = 32'h0;
    h = {1'b1, 1'b0, ^{ap, rnw, a} ^ bad[0], a[1], a[0], rnw, ap, 1'b1};
    for (int i = 0; i < 8; i++) bitx(h[i], 1'b1, s);
    bitx(1'b0, 1'b0, s);
    for (int i = 0; i < 3; i++) begin
      bitx(1'b0, 1'b0, s);
      ack[i] = s;
    end
    if (ack === ACK_OK && rnw) begin
      for (int i = 0; i < 32; i++) begin
        bitx(1'b0, 1'b0, s);
        rd[i] = s;
      end
      bitx(1'b0, 1'b0, p);
      bitx(1'b0, 1'b0, s);
      if ((^rd) !== p) ack = 3'h7;
    end else if (ack === ACK_OK) begin
      bitx(1'b0, 1'b0, s);
      for (int i = 0; i < 32; i++) bitx(wd[i], 1'b1, s);
      bitx(^wd ^ bad[1], 1'b1, s);
    end
    repeat (8) bitx(1'b0, 1'b1, s);
  endtask : xfer
endmodule : swd_host_model

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import swd_pkg::*;
  localparam logic [31:0] IDENT = 32'h0BAD_F00D; // Arbitrary identification value.
  logic clk_i = 1'b0;
  logic rst_bench = 1'b1;
  logic rst_i, external_reset_pin_n, supply_on;
  logic link_clk_i, host_d, host_oe, link_data_i, link_data_o, link_data_oe_o, abort_pulse_o, line_synced_o;
  logic [31:0] mem_read_data_i = 32'hA5C3_0F96;
  logic [31:0] control_status_o, rd;
  logic [2:0] ack;
  mem_write_type mem_write_o, mw_last;
  int error_cnt = 0;
  int n_compared = 0;
  int aborts = 0;
  // The line has a pull-up when nobody drives it.
  assign link_data_i = link_data_oe_o ? link_data_o : (host_oe ? host_d : 1'b1);
  // The target is held in reset by the bench, by its reset pin and while it is unpowered.
  assign rst_i = rst_bench | ~external_reset_pin_n | ~supply_on;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (mem_write_o.valid === 1'b1) mw_last <= mem_write_o;
    if (abort_pulse_o === 1'b1) aborts <= aborts + 1;
  end
  swd_host_model swd_host_model_inst (.link_clk_o(link_clk_i), .data_o(host_d), .oe_o(host_oe),
    .line_i(link_data_i), .external_reset_pin_n_o(external_reset_pin_n), .supply_on_o(supply_on));
  swd_dap_access #(.IDENT_VALUE(IDENT)) swd_dap_access_inst (.clk_i, .rst_i, .link_clk_i, .link_data_i,
    .link_data_o, .link_data_oe_o, .mem_read_data_i, .mem_write_o, .control_status_o, .abort_pulse_o,
    .line_synced_o);
  task automatic check(input logic [34:0] got, input logic [34:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic ap, input logic [1:0] a, input logic [31:0] d, input logic [1:0] bad,
                    input logic [2:0] exp_ack);
    swd_host_model_inst.xfer(ap, 1'b0, a, d, bad, rd, ack);
    check(ack, exp_ack, "write ack");
  endtask : wr
  task automatic rdc(input logic ap, input logic [1:0] a, input logic [31:0] exp);
    swd_host_model_inst.xfer(ap, 1'b1, a, 32'h0, 2'h0, rd, ack);
    check({ack, rd}, {ACK_OK, exp}, "read ack and data");
  endtask : rdc
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge clk_i);
    #2 rst_bench = 1'b0;
    wr(PORT_DEBUG, DP_CONTROL_STATUS_ADDR, 32'h0000_00F0, 2'h0, 3'h7);
    check(control_status_o, CONTROL_STATUS_RESET, "status before sync");
    swd_host_model_inst.line_reset(49);
    check(line_synced_o, 1'b0, "sync after 49 high bits");
    swd_host_model_inst.line_reset(50);
    check(line_synced_o, 1'b1, "sync after 50 high bits");
    rdc(PORT_DEBUG, DP_IDENT_ABORT_ADDR, IDENT);
    wr(PORT_DEBUG, DP_CONTROL_STATUS_ADDR, 32'h5000_00F1, 2'h0, ACK_OK);
    check(control_status_o, 32'h5000_00F1, "status port");
    rdc(PORT_DEBUG, DP_CONTROL_STATUS_ADDR, 32'h5000_00F1);
    wr(PORT_ACCESS, AP_CONTROL_WORD_ADDR, 32'h2300_0052, 2'h0, ACK_OK);
    rdc(PORT_ACCESS, AP_CONTROL_WORD_ADDR, 32'h2300_0052);
    rdc(PORT_DEBUG, DP_IDENT_ABORT_ADDR, IDENT);
    wr(PORT_ACCESS, AP_TRANSFER_ADDRESS_ADDR, 32'h2000_0400, 2'h0, ACK_OK);
    rdc(PORT_ACCESS, AP_TRANSFER_ADDRESS_ADDR, 32'h2000_0400);
    wr(PORT_ACCESS, AP_DATA_WINDOW_ADDR, 32'h1234_5678, 2'h0, ACK_OK);
    check(mw_last.addr, 32'h2000_0400, "window write address");
    check(mw_last.data, 32'h1234_5678, "window write data");
    rdc(PORT_ACCESS, AP_DATA_WINDOW_ADDR, 32'hA5C3_0F96);
    rdc(PORT_ACCESS, 2'h2, 32'h0);
    wr(PORT_DEBUG, DP_BANK_SELECT_ADDR, 32'h0000_00F0, 2'h0, ACK_OK);
    wr(PORT_DEBUG, DP_IDENT_ABORT_ADDR, 32'h0000_001E, 2'h0, ACK_OK);
    check(35'(aborts), 35'h1, "abort pulses");
    wr(PORT_DEBUG, DP_CONTROL_STATUS_ADDR, 32'h0, 2'h1, 3'h7);
    wr(PORT_DEBUG, DP_CONTROL_STATUS_ADDR, 32'h0, 2'h2, ACK_OK);
    check(control_status_o, 32'h5000_00F1, "status after refused writes");
    swd_host_model_inst.pulse_target_reset();
    check(line_synced_o, 1'b0, "sync after target reset");
    check(control_status_o, CONTROL_STATUS_RESET, "status after target reset");
    wr(PORT_DEBUG, DP_CONTROL_STATUS_ADDR, 32'h0000_0033, 2'h0, 3'h7);
    swd_host_model_inst.line_reset(50);
    wr(PORT_DEBUG, DP_CONTROL_STATUS_ADDR, 32'h0000_0033, 2'h0, ACK_OK);
    check(control_status_o, 32'h0000_0033, "status after resync");
    swd_host_model_inst.set_supply(1'b0);
    check(line_synced_o, 1'b0, "sync while unpowered");
    swd_host_model_inst.set_supply(1'b1);
    swd_host_model_inst.line_reset(50);
    rdc(PORT_DEBUG, DP_CONTROL_STATUS_ADDR, CONTROL_STATUS_RESET);
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : testbench
bind swd_dap_access swd_dap_access_properties swd_dap_access_properties_inst (.clk_i, .rst_i, .link_clk_i,
  .link_data_i, .link_data_o, .link_data_oe_o, .mem_read_data_i, .mem_write_o, .control_status_o,
  .abort_pulse_o, .line_synced_o);

// ---- src/swd_bit_sync.sv ----
`timescale 1ns/1ns
// Two-stage synchroniser for the link pins, with edge detection on the
// second stage output only.
module swd_bit_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic clk_pin_i,
  input wire logic data_pin_i,
  // Synchronised results
  output logic data_o,
  output logic rise_o,
  output logic fall_o
);
  logic [1:0] clk_meta_reg;
  logic [1:0] data_meta_reg;
  logic clk_prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_meta_reg <= 2'h0;
      data_meta_reg <= 2'h0;
      clk_prev_reg <= 1'b0;
    end else begin
      clk_meta_reg <= {clk_meta_reg[0], clk_pin_i};
      data_meta_reg <= {data_meta_reg[0], data_pin_i};
      clk_prev_reg <= clk_meta_reg[1];
    end
  end

  assign data_o = data_meta_reg[1];
  assign rise_o = clk_meta_reg[1] & ~clk_prev_reg;
  assign fall_o = ~clk_meta_reg[1] & clk_prev_reg;
endmodule : swd_bit_sync

// ---- src/swd_dap_access.sv ----
`timescale 1ns/1ns
// Functional notes
// - Only read, write and line reset accepted.
// - Line reset first; needed before any access.
// - Write carries 32 bits; target returns ack.
// - Read returns word, ack and parity.
// - Port select 0 debug port, 1 access.
// - Debug port: ident/abort, control-status, bank select.
// - Access port: control word, address, data window.
module swd_dap_access #(
  parameter logic [31:0] IDENT_VALUE = 32'h1234_5671  // Arbitrary identification value.
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link pins
  input wire logic link_clk_i,
  input wire logic link_data_i,
  output logic link_data_o,
  output logic link_data_oe_o,
  // Memory side of the access port, plus status, abort and sync outputs
  input wire logic [31:0] mem_read_data_i,
  output swd_pkg::mem_write_type mem_write_o,
  output logic [31:0] control_status_o,
  output logic abort_pulse_o,
  output logic line_synced_o
);
  import swd_pkg::*;

  logic data_in;
  logic clk_rise;
  logic clk_fall;
  link_state_type state_reg;
  logic [5:0] high_count_reg;
  logic [5:0] bit_count_reg;
  logic [7:0] header_reg;
  request_type req_reg;
  logic [31:0] shift_reg;
  logic parity_reg;
  logic [2:0] ack_reg;
  logic synced_reg;
  logic [31:0] control_status_reg;
  logic [31:0] bank_select_reg;
  logic [31:0] control_word_reg;
  logic [31:0] transfer_address_reg;
  mem_write_type mem_write_reg;
  logic abort_reg;
  logic data_out_reg;
  logic data_oe_reg;
  logic [7:0] hdr_next;
  logic header_ok;

  swd_bit_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_pin_i(link_clk_i),
    .data_pin_i(link_data_i),
    .data_o(data_in),
    .rise_o(clk_rise),
    .fall_o(clk_fall)
  );

  // Valid header: start 1, stop 0, park 1, even parity over four fields.
  function automatic logic header_valid(input logic [7:0] h);
    header_valid = h[HDR_START] & ~h[HDR_STOP] & h[HDR_PARK]
      & ~(h[HDR_APNDP] ^ h[HDR_RNW] ^ h[HDR_A2] ^ h[HDR_A3] ^ h[HDR_PARITY]);
  endfunction : header_valid

  // Read mux over the debug-port and access-port register sets.
  function automatic logic [31:0] read_word(input request_type r, input logic [31:0] cs,
                                            input logic [31:0] cw, input logic [31:0] ta,
                                            input logic [31:0] md);
    read_word = 32'h0000_0000;
    if (r.port_sel == PORT_DEBUG) begin
      case (r.addr)
        DP_IDENT_ABORT_ADDR: read_word = IDENT_VALUE;
        DP_CONTROL_STATUS_ADDR: read_word = cs;
        default: read_word = 32'h0000_0000;
      endcase
    end else begin
      case (r.addr)
        AP_CONTROL_WORD_ADDR: read_word = cw;
        AP_TRANSFER_ADDRESS_ADDR: read_word = ta;
        AP_DATA_WINDOW_ADDR: read_word = md;
        default: read_word = 32'h0000_0000;
      endcase
    end
  endfunction : read_word

  assign hdr_next = {data_in, header_reg[7:1]};
  assign header_ok = header_valid(hdr_next);

  // Line reset detection on rising link clock edges.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_count_reg <= 6'h00;
    end else if (clk_rise) begin
      if (!data_in) begin
        high_count_reg <= 6'h00;
      end else if (high_count_reg != LINE_RESET_COUNT_MAX) begin
        high_count_reg <= high_count_reg + 6'h01;
      end
    end
  end

  // Packet engine: host drives on falling edges, target samples on rising.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_RESET;
      bit_count_reg <= 6'h00;
      header_reg <= 8'h00;
      req_reg <= '0;
      shift_reg <= 32'h0000_0000;
      parity_reg <= 1'b0;
      ack_reg <= ACK_OK;
      synced_reg <= 1'b0;
    end else if (clk_rise && data_in && high_count_reg == LINE_RESET_COUNT_MAX - 6'h01) begin
      state_reg <= ST_RESET;
      synced_reg <= 1'b1;
    end else if (clk_rise) begin
      case (state_reg)
        ST_RESET: begin
          if (!data_in && synced_reg) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (data_in) begin
            header_reg <= {data_in, 7'h00};
            bit_count_reg <= 6'h01;
            state_reg <= ST_HEADER;
          end
        end
        ST_HEADER: begin
          header_reg <= hdr_next;
          bit_count_reg <= bit_count_reg + 6'h01;
          if (bit_count_reg == HEADER_BITS - 6'h01) begin
            bit_count_reg <= 6'h00;
            if (header_ok) begin
              req_reg <= '{port_sel: hdr_next[HDR_APNDP], read_not_write: hdr_next[HDR_RNW],
                           addr: {hdr_next[HDR_A3], hdr_next[HDR_A2]}};
              state_reg <= ST_TURN_TO_TARGET;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_TURN_TO_TARGET: begin
          ack_reg <= ACK_OK;
          shift_reg <= {29'h0000_0000, ACK_OK};
          state_reg <= ST_ACK;
        end
        ST_ACK: begin
          bit_count_reg <= bit_count_reg + 6'h01;
          if (bit_count_reg == ACK_BITS - 6'h01) begin
            bit_count_reg <= 6'h00;
            if (req_reg.read_not_write) begin
              shift_reg <= read_word(req_reg, control_status_reg, control_word_reg,
                                     transfer_address_reg, mem_read_data_i);
              state_reg <= ST_READ_DATA;
            end else begin
              state_reg <= ST_TURN_TO_HOST;
            end
          end
        end
        ST_READ_DATA: begin
          bit_count_reg <= bit_count_reg + 6'h01;
          if (bit_count_reg == DATA_BITS) begin
            bit_count_reg <= 6'h00;
            state_reg <= ST_TURN_TO_HOST;
          end
        end
        ST_TURN_TO_HOST: begin
          bit_count_reg <= 6'h00;
          parity_reg <= 1'b0;
          state_reg <= req_reg.read_not_write ? ST_IDLE : ST_WRITE_DATA;
        end
        ST_WRITE_DATA: begin
          bit_count_reg <= bit_count_reg + 6'h01;
          if (bit_count_reg == DATA_BITS) begin
            bit_count_reg <= 6'h00;
            state_reg <= ST_IDLE;
          end else begin
            shift_reg <= {data_in, shift_reg[31:1]};
            parity_reg <= parity_reg ^ data_in;
          end
        end
        default: state_reg <= ST_DISCARD == state_reg ? ST_IDLE : ST_RESET;
      endcase
    end
  end

  // Register writes land after the data parity bit checks out.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_status_reg <= CONTROL_STATUS_RESET;
      bank_select_reg <= BANK_SELECT_RESET;
      control_word_reg <= CONTROL_WORD_RESET;
      transfer_address_reg <= TRANSFER_ADDRESS_RESET;
      mem_write_reg <= '0;
      abort_reg <= 1'b0;
    end else begin
      mem_write_reg.valid <= 1'b0;
      abort_reg <= 1'b0;
      if (clk_rise && state_reg == ST_WRITE_DATA && bit_count_reg == DATA_BITS
          && (parity_reg == data_in)) begin
        if (req_reg.port_sel == PORT_DEBUG) begin
          case (req_reg.addr)
            DP_IDENT_ABORT_ADDR: abort_reg <= 1'b1;
            DP_CONTROL_STATUS_ADDR: control_status_reg <= shift_reg;
            DP_BANK_SELECT_ADDR: bank_select_reg <= shift_reg;
            default: abort_reg <= 1'b0;
          endcase
        end else begin
          case (req_reg.addr)
            AP_CONTROL_WORD_ADDR: control_word_reg <= shift_reg;
            AP_TRANSFER_ADDRESS_ADDR: transfer_address_reg <= shift_reg;
            AP_DATA_WINDOW_ADDR: mem_write_reg <= '{valid: 1'b1, addr: transfer_address_reg,
                                                    data: shift_reg};
            default: abort_reg <= 1'b0;
          endcase
        end
      end
    end
  end

  // Target drives the line on falling edges during acknowledge and read data.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_out_reg <= 1'b0;
      data_oe_reg <= 1'b0;
    end else if (clk_fall) begin
      case (state_reg)
        ST_ACK: begin
          data_oe_reg <= 1'b1;
          data_out_reg <= ack_reg[bit_count_reg[1:0]];
        end
        ST_READ_DATA: begin
          data_oe_reg <= 1'b1;
          if (bit_count_reg == DATA_BITS) begin
            data_out_reg <= ^shift_reg;
          end else begin
            data_out_reg <= shift_reg[bit_count_reg[4:0]];
          end
        end
        default: begin
          data_oe_reg <= 1'b0;
          data_out_reg <= 1'b0;
        end
      endcase
    end
  end

  assign link_data_o = data_out_reg;
  assign link_data_oe_o = data_oe_reg;
  assign mem_write_o = mem_write_reg;
  assign control_status_o = control_status_reg;
  assign abort_pulse_o = abort_reg;
  assign line_synced_o = synced_reg;
endmodule : swd_dap_access

// ---- src/swd_pkg.sv ----
package swd_pkg;

  // Port select values.
  localparam logic PORT_DEBUG = 1'b0;
  localparam logic PORT_ACCESS = 1'b1;

  // Debug-port register addresses.
  localparam logic [1:0] DP_IDENT_ABORT_ADDR = 2'h0;
  localparam logic [1:0] DP_CONTROL_STATUS_ADDR = 2'h1;
  localparam logic [1:0] DP_BANK_SELECT_ADDR = 2'h2;

  // Access-port register addresses.
  localparam logic [1:0] AP_CONTROL_WORD_ADDR = 2'h0;
  localparam logic [1:0] AP_TRANSFER_ADDRESS_ADDR = 2'h1;
  localparam logic [1:0] AP_DATA_WINDOW_ADDR = 2'h3;

  // Acknowledge codes, sent least significant bit first.
  localparam logic [2:0] ACK_OK = 3'h1;
  localparam logic [2:0] ACK_FAULT = 3'h4;

  // Reset values of the stored registers.
  localparam logic [31:0] CONTROL_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] BANK_SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] TRANSFER_ADDRESS_RESET = 32'h0000_0000;

  // Line reset: high clocks needed before the line counts as reset.
  localparam int LINE_RESET_HIGH_CLOCKS = 50;
  localparam logic [5:0] LINE_RESET_COUNT_MAX = 6'h32;

  // Header, data and acknowledge bit counts.
  localparam logic [5:0] HEADER_BITS = 6'h08;
  localparam logic [5:0] DATA_BITS = 6'h20;
  localparam logic [5:0] ACK_BITS = 6'h03;

  // Header field positions, bits in arrival order.
  localparam int HDR_START = 0;
  localparam int HDR_APNDP = 1;
  localparam int HDR_RNW = 2;
  localparam int HDR_A2 = 3;
  localparam int HDR_A3 = 4;
  localparam int HDR_PARITY = 5;
  localparam int HDR_STOP = 6;
  localparam int HDR_PARK = 7;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_HEADER = 4'h2,
    ST_TURN_TO_TARGET = 4'h3,
    ST_ACK = 4'h4,
    ST_READ_DATA = 4'h5,
    ST_TURN_TO_HOST = 4'h6,
    ST_WRITE_DATA = 4'h7,
    ST_DISCARD = 4'h8
  } link_state_type;

  // Decoded request carried from the header to the data phase.
  typedef struct packed {
    logic port_sel;
    logic read_not_write;
    logic [1:0] addr;
  } request_type;

  // Write strobe toward the memory side of the access port.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } mem_write_type;

endpackage : swd_pkg
